// ### logic/pic_params.svh
// Register offsets, field positions, reset values and widths for the input path config
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH

`define PIC_ADDR_W 8
`define PIC_DATA_W 8
`define PIC_DIV_W 16

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PIC_OFS_PATH_CTRL 8'h1b
`define PIC_OFS_MISC_CTRL 8'h1c

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PIC_RST_PATH_CTRL 8'h00
`define PIC_RST_MISC_CTRL 8'h00

// ----------------------------------------
// Path control fields
// ----------------------------------------
`define PIC_B_TEST_BYPASS 7
`define PIC_B_FB_BYPASS 6
`define PIC_B_ZD_INTERNAL 5
`define PIC_B_FB_FROM_OSC 4
`define PIC_B_ZD_PIN_SEL 3
`define PIC_B_ZD_DIFF 2
`define PIC_B_SEC_PIN_SEL 1
`define PIC_B_PRI_PIN_SEL 0

// ----------------------------------------
// Misc control fields
// ----------------------------------------
`define PIC_B_SEC_INDEP 7
`define PIC_B_TUNE_MID 6
`define PIC_B_RESERVED 5
`define PIC_B_MODE_HI 4
`define PIC_B_MODE_LO 2
`define PIC_B_SEC_BYPASS 1
`define PIC_B_PRI_BYPASS 0

// Divide-by-one word loaded while a divider is bypassed
`define PIC_DIV_ONE 16'h0001
`define PIC_BYTE_ZERO 8'h00

`endif

// ### logic/pic_pkg.sv
// Types shared by the input path config modules
`default_nettype none
`include "pic_params.svh"

package pic_pkg;

	typedef enum logic [0:0] {
		PIC_ON_PRIMARY = 1'b0,
		PIC_ON_SECONDARY = 1'b1
	} pic_ref_state_t;

	typedef enum logic [2:0] {
		PIC_MODE_NONREVERT = 3'b000,
		PIC_MODE_REVERT = 3'b001,
		PIC_MODE_FORCE_PRI = 3'b010,
		PIC_MODE_FORCE_SEC = 3'b011
	} pic_sel_mode_t;

	typedef struct packed {
		pic_ref_state_t state;
	} pic_sel_regs_t;

	typedef struct packed {
		logic [`PIC_DATA_W-1:0] path_ctrl;
		logic [`PIC_DATA_W-1:0] misc_ctrl;
		logic [`PIC_DATA_W-1:0] rdata;
		logic rvalid;
		logic [`PIC_DIV_W-1:0] test_div;
		logic [`PIC_DIV_W-1:0] fb_div;
		logic [`PIC_DIV_W-1:0] pri_div;
		logic [`PIC_DIV_W-1:0] sec_div;
		logic fb_from_osc;
		logic zd_rx_en;
		logic zd_internal;
		logic zd_diff;
		logic zd_pin_sel;
		logic pri_pin_sel;
		logic sec_pin_sel;
		logic tune_mid;
		logic tune_hiz;
	} pic_regs_t;

endpackage

`default_nettype wire

// ### logic/pic_ref_select.sv
// Reference selection between primary and secondary inputs
`default_nettype none
`include "pic_params.svh"

module pic_ref_select
	import pic_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Control
	input wire logic [2:0] mode_in,
	input wire logic ref_sel_pin_in,
	input wire logic primary_lost_in,
	input wire logic secondary_lost_in,
	// Status
	output logic on_secondary_out
);

	pic_sel_regs_t r;
	pic_sel_regs_t next_r;

	always_comb begin
		next_r = r;
		if (mode_in[2]) begin
			// Pin picks the reference directly [R14]
			next_r.state = ref_sel_pin_in ? PIC_ON_SECONDARY : PIC_ON_PRIMARY;
		end else begin
			case (mode_in)
				PIC_MODE_FORCE_PRI: next_r.state = PIC_ON_PRIMARY;
				PIC_MODE_FORCE_SEC: next_r.state = PIC_ON_SECONDARY;
				PIC_MODE_NONREVERT, PIC_MODE_REVERT: begin
					if (r.state == PIC_ON_PRIMARY) begin
						if (primary_lost_in && !secondary_lost_in) begin
							next_r.state = PIC_ON_SECONDARY;
						end
					end else if (mode_in == PIC_MODE_REVERT && !primary_lost_in) begin
						// Revert once primary is healthy; nonrevertive stays [R15]
						next_r.state = PIC_ON_PRIMARY;
					end else if (secondary_lost_in && !primary_lost_in) begin
						// In mode 000, leaving a dead secondary is the only way back here
						next_r.state = PIC_ON_PRIMARY;
					end
				end
				default: next_r.state = r.state;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r <= '{state: PIC_ON_PRIMARY};
		end else begin
			r <= next_r;
		end
	end

	assign on_secondary_out = (r.state == PIC_ON_SECONDARY);

endmodule

`default_nettype wire

// ### logic/pic_input_path.sv
// Input loop reference and feedback path configuration registers
//
// Functional notes
// (R1) Bypass bit forces test or feedback divider to divide by one.
// (R2) Zero-delay mode bit only counts while feedback source bit is zero.
// (R3) Internal zero-delay powers down receiver, uses channel 0 internal path.
// (R4) Feedback source bit one uses oscillator input; zero enables zero delay.
// (R5) Zero-delay receiver differential when bit 2 set, else single-ended.
// (R6) Single-ended zero-delay receiver: bit 3 chooses the enabled pin.
// (R7) Single-ended secondary receiver: bit 1 chooses the enabled pin.
// (R8) Single-ended primary receiver: bit 0 chooses the enabled pin.
// (R9) Independent bit set: secondary divider uses its own divide word.
// (R10) Independent bit clear: secondary divider copies primary's word.
// (R11) Tune-midsupply bit set and clock failure force tune output midsupply.
// (R12) Tune-midsupply bit clear: tune output follows tristated charge pump.
// (R13) Selection mode field resets to 000, automatic nonrevertive.
// (R14) Mode top bit set: selection pin picks primary low, secondary high.
// (R15) Mode 000 stays on secondary; mode 001 reverts to primary.
// (R16) Software writes reserved bit 5 as zero, ignores its read value.
`default_nettype none
`include "pic_params.svh"

module pic_input_path
	import pic_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	// Register port
	input wire logic [`PIC_ADDR_W-1:0] reg_addr_in,
	input wire logic [`PIC_DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [`PIC_DATA_W-1:0] reg_rdata_out,
	output logic reg_rvalid_out,
	// Divider words from neighbouring registers
	input wire logic [`PIC_DIV_W-1:0] test_ref_div_word_in,
	input wire logic [`PIC_DIV_W-1:0] feedback_div_word_in,
	input wire logic [`PIC_DIV_W-1:0] primary_ref_div_word_in,
	input wire logic [`PIC_DIV_W-1:0] secondary_ref_div_word_in,
	// Receiver mode settings held elsewhere
	input wire logic primary_ref_input_diff_in,
	input wire logic secondary_ref_input_diff_in,
	// Clock health and selection pin
	input wire logic clock_fail_in,
	input wire logic primary_ref_lost_in,
	input wire logic secondary_ref_lost_in,
	input wire logic ref_sel_pin_in,
	// Effective divide words
	output logic [`PIC_DIV_W-1:0] test_ref_div_out,
	output logic [`PIC_DIV_W-1:0] feedback_div_out,
	output logic [`PIC_DIV_W-1:0] primary_ref_div_out,
	output logic [`PIC_DIV_W-1:0] secondary_ref_div_out,
	// Feedback path steering
	output logic feedback_from_oscillator_input_out,
	output logic zero_delay_feedback_input_rx_en_out,
	output logic zero_delay_internal_path_out,
	// Receiver modes
	output logic zero_delay_feedback_input_diff_out,
	output logic zero_delay_feedback_input_pin_sel_out,
	output logic primary_reference_input_pin_sel_out,
	output logic secondary_reference_input_pin_sel_out,
	// Oscillator tune output control
	output logic oscillator_tune_output_mid_out,
	output logic oscillator_tune_output_hiz_out,
	// Reference selection
	output logic secondary_ref_active_out
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [`PIC_DIV_W-1:0] eff_div(input logic [`PIC_DIV_W-1:0] word,
		input logic bypass);
		eff_div = bypass ? `PIC_DIV_ONE : word;
	endfunction

	// Address decode shared by the write and read sides
	function automatic logic hits(input logic [`PIC_ADDR_W-1:0] addr,
		input logic [`PIC_ADDR_W-1:0] offset);
		hits = (addr == offset);
	endfunction

	// A pin choice only exists while the receiver is single-ended
	function automatic logic se_pin(input logic diff, input logic sel);
		se_pin = !diff && sel;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	pic_regs_t r;
	pic_regs_t next_r;
	logic [`PIC_DIV_W-1:0] sec_word;
	logic zd_path_sel;

	always_comb begin
		next_r = r;
		next_r.rvalid = 1'b0;
		sec_word = primary_ref_div_word_in;
		zd_path_sel = 1'b0;

		// ----------------------------------------
		// Register writes
		// ----------------------------------------
		// The reserved bit is dropped so it always reads zero
		if (reg_wr_in) begin
			if (hits(reg_addr_in, `PIC_OFS_PATH_CTRL)) begin
				next_r.path_ctrl = reg_wdata_in;
			end else if (hits(reg_addr_in, `PIC_OFS_MISC_CTRL)) begin
				next_r.misc_ctrl = reg_wdata_in;
				next_r.misc_ctrl[`PIC_B_RESERVED] = 1'b0; // [R16]
			end
		end

		// ----------------------------------------
		// Register reads
		// ----------------------------------------
		// A read beside a write in one cycle returns the old value
		if (reg_rd_in) begin
			next_r.rvalid = 1'b1;
			if (hits(reg_addr_in, `PIC_OFS_PATH_CTRL)) begin
				next_r.rdata = r.path_ctrl;
			end else if (hits(reg_addr_in, `PIC_OFS_MISC_CTRL)) begin
				next_r.rdata = r.misc_ctrl;
			end else begin
				// Unmapped offsets read as zero
				next_r.rdata = `PIC_BYTE_ZERO;
			end
		end

		// ----------------------------------------
		// Divider words
		// ----------------------------------------
		// A bypassed divider is handed a divide word of one
		next_r.test_div = eff_div(test_ref_div_word_in, r.path_ctrl[`PIC_B_TEST_BYPASS]); // [R1]
		next_r.fb_div = eff_div(feedback_div_word_in, r.path_ctrl[`PIC_B_FB_BYPASS]); // [R1]
		next_r.pri_div = eff_div(primary_ref_div_word_in, r.misc_ctrl[`PIC_B_PRI_BYPASS]);
		// Tied mode only stays locked with equal input frequencies
		sec_word = r.misc_ctrl[`PIC_B_SEC_INDEP] ? secondary_ref_div_word_in // [R9]
			: primary_ref_div_word_in; // [R10]
		next_r.sec_div = eff_div(sec_word, r.misc_ctrl[`PIC_B_SEC_BYPASS]);

		// ----------------------------------------
		// Feedback path
		// ----------------------------------------
		// Exactly one of the three feedback outputs is high from the first clock after reset
		next_r.fb_from_osc = r.path_ctrl[`PIC_B_FB_FROM_OSC]; // [R4]
		// Zero-delay mode bit is ignored while oscillator feedback is chosen
		zd_path_sel = !r.path_ctrl[`PIC_B_FB_FROM_OSC]; // [R2]
		next_r.zd_rx_en = zd_path_sel && !r.path_ctrl[`PIC_B_ZD_INTERNAL]; // [R2] [R3]
		next_r.zd_internal = zd_path_sel && r.path_ctrl[`PIC_B_ZD_INTERNAL]; // [R3]

		// ----------------------------------------
		// Receiver pins
		// ----------------------------------------
		next_r.zd_diff = r.path_ctrl[`PIC_B_ZD_DIFF]; // [R5]
		// Reference receiver modes are held in a neighbouring register
		next_r.zd_pin_sel = se_pin(r.path_ctrl[`PIC_B_ZD_DIFF],
			r.path_ctrl[`PIC_B_ZD_PIN_SEL]); // [R6]
		next_r.sec_pin_sel = se_pin(secondary_ref_input_diff_in,
			r.path_ctrl[`PIC_B_SEC_PIN_SEL]); // [R7]
		next_r.pri_pin_sel = se_pin(primary_ref_input_diff_in,
			r.path_ctrl[`PIC_B_PRI_PIN_SEL]); // [R8]

		// ----------------------------------------
		// Oscillator tune output
		// ----------------------------------------
		// On clock failure without the midsupply bit the pump is left high impedance
		next_r.tune_mid = clock_fail_in && r.misc_ctrl[`PIC_B_TUNE_MID]; // [R11]
		next_r.tune_hiz = clock_fail_in && !r.misc_ctrl[`PIC_B_TUNE_MID]; // [R12]
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Reset loads constants only, so the clear stays glitch free
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			r <= '0;
			r.path_ctrl <= `PIC_RST_PATH_CTRL;
			r.misc_ctrl <= `PIC_RST_MISC_CTRL; // [R13]
		end else begin
			r <= next_r;
		end
	end

	// ----------------------------------------
	// Reference selection
	// ----------------------------------------
	pic_ref_select u_ref_select (
		.sys_clk_in(sys_clk_in),
		.rst_n_in(rst_n_in),
		.mode_in(r.misc_ctrl[`PIC_B_MODE_HI:`PIC_B_MODE_LO]), // [R14] [R15]
		.ref_sel_pin_in(ref_sel_pin_in),
		.primary_lost_in(primary_ref_lost_in),
		.secondary_lost_in(secondary_ref_lost_in),
		.on_secondary_out(secondary_ref_active_out)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Every output is a register bit, so no decode reaches a pin
	assign reg_rdata_out = r.rdata;
	assign reg_rvalid_out = r.rvalid;
	assign test_ref_div_out = r.test_div;
	assign feedback_div_out = r.fb_div;
	assign primary_ref_div_out = r.pri_div;
	assign secondary_ref_div_out = r.sec_div;
	assign feedback_from_oscillator_input_out = r.fb_from_osc;
	assign zero_delay_feedback_input_rx_en_out = r.zd_rx_en;
	assign zero_delay_internal_path_out = r.zd_internal;
	assign zero_delay_feedback_input_diff_out = r.zd_diff;
	assign zero_delay_feedback_input_pin_sel_out = r.zd_pin_sel;
	assign primary_reference_input_pin_sel_out = r.pri_pin_sel;
	assign secondary_reference_input_pin_sel_out = r.sec_pin_sel;
	assign oscillator_tune_output_mid_out = r.tune_mid;
	assign oscillator_tune_output_hiz_out = r.tune_hiz;

endmodule

`default_nettype wire

// ### verification/pic_input_path_chk.sv
// Assertion checker bound to the input path configuration block
`default_nettype none
module pic_input_path_chk (
	// Clock, reset and register port
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic reg_rvalid_out,
	// Watched path inputs and outputs
	input wire logic [15:0] test_ref_div_out,
	input wire logic primary_ref_input_diff_in,
	input wire logic clock_fail_in,
	input wire logic feedback_from_oscillator_input_out,
	input wire logic zero_delay_feedback_input_rx_en_out,
	input wire logic zero_delay_internal_path_out,
	input wire logic zero_delay_feedback_input_diff_out,
	input wire logic zero_delay_feedback_input_pin_sel_out,
	input wire logic primary_reference_input_pin_sel_out,
	input wire logic oscillator_tune_output_mid_out,
	input wire logic oscillator_tune_output_hiz_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
		else $error("read not answered");
	a_no_stray_valid: assert property (!reg_rd_in |=> !reg_rvalid_out)
		else $error("read valid without read");
	a_test_bypass: assert property (
		reg_wr_in && reg_addr_in == 8'h1b && reg_wdata_in[7] |-> ##2 test_ref_div_out == 16'h0001)
		else $error("test divider not bypassed");
	a_zd_onehot: assert property (
		$past(rst_n_in) |->
		$onehot({feedback_from_oscillator_input_out, zero_delay_feedback_input_rx_en_out,
		zero_delay_internal_path_out})) else $error("feedback path not unique");
	a_zd_pin_gate: assert property (
		zero_delay_feedback_input_pin_sel_out |-> !zero_delay_feedback_input_diff_out)
		else $error("zero delay pin select while differential");
	a_pri_pin_gate: assert property (
		primary_reference_input_pin_sel_out |-> !$past(primary_ref_input_diff_in))
		else $error("primary pin select while differential");
	a_tune_mid: assert property (oscillator_tune_output_mid_out |-> $past(clock_fail_in))
		else $error("tune forced without failure");
	a_tune_fail: assert property (
		$past(clock_fail_in) && $past(rst_n_in) |->
		oscillator_tune_output_mid_out ^ oscillator_tune_output_hiz_out)
		else $error("tune output not handled on failure");
	cover property (reg_rvalid_out);
	cover property (oscillator_tune_output_mid_out);
	cover property (zero_delay_internal_path_out);
endmodule
bind pic_input_path pic_input_path_chk i_chk (.*);
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the input path configuration block
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, fail = 0, pd = 0, sd = 0, pl = 0, pin = 0;
	logic [7:0] adr = 0, wd = 0, rdat, path, misc;
	logic [15:0] tw = 0, fw = 0, pw = 0, sw = 0, dt, df, dp, ds;
	logic [6:0] pth;
	logic [1:0] tune;
	logic rv, act;
	logic sl = 0;
	logic [31:0] seed = 68;
	int mismatches = 0, comparisons = 0;
	// Mode byte, secondary lost, primary lost, selection pin, expected secondary flag
	logic [11:0] tbl [12] = '{12'h005, 12'h001, 12'h040, 12'h045, 12'h040, 12'h082, 12'h0c1,
		12'h100, 12'h103, 12'h1c3, 12'h008, 12'h00c};
	pic_input_path i_dut (.sys_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(adr),
		.reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat),
		.reg_rvalid_out(rv), .test_ref_div_word_in(tw), .feedback_div_word_in(fw),
		.primary_ref_div_word_in(pw), .secondary_ref_div_word_in(sw),
		.primary_ref_input_diff_in(pd), .secondary_ref_input_diff_in(sd), .clock_fail_in(fail),
		.primary_ref_lost_in(pl), .secondary_ref_lost_in(sl), .ref_sel_pin_in(pin),
		.test_ref_div_out(dt), .feedback_div_out(df), .primary_ref_div_out(dp),
		.secondary_ref_div_out(ds), .feedback_from_oscillator_input_out(pth[6]),
		.zero_delay_feedback_input_rx_en_out(pth[5]), .zero_delay_internal_path_out(pth[4]),
		.zero_delay_feedback_input_diff_out(pth[3]),
		.zero_delay_feedback_input_pin_sel_out(pth[2]),
		.primary_reference_input_pin_sel_out(pth[1]),
		.secondary_reference_input_pin_sel_out(pth[0]),
		.oscillator_tune_output_mid_out(tune[1]), .oscillator_tune_output_hiz_out(tune[0]),
		.secondary_ref_active_out(act));
	initial begin
		forever #20 clk = ~clk;
	end
	function void step();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
	endfunction
	function logic [15:0] byp(input logic b, input logic [15:0] w);
		return b ? 16'h0001 : w;
	endfunction
	task check(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr_reg(input logic [7:0] a_v, input logic [7:0] d_v);
		@(posedge clk) #1;
		adr = a_v;
		wd = d_v;
		wr = 1;
		@(posedge clk) #1;
		wr = 0;
	endtask
	// Read data is taken in the cycle the valid pulse stands
	task rd_reg(input logic [7:0] a_v, input logic [7:0] exp);
		@(posedge clk) #1;
		adr = a_v;
		rd = 1;
		@(posedge clk) #1;
		rd = 0;
		check(64'({rv, rdat}), 64'({1'b1, exp}));
	endtask
	task check_all;
		@(posedge clk) #1;
		check({dt, df, dp, 16'h0}, {byp(path[7], tw), byp(path[6], fw), byp(misc[0], pw), 16'h0});
		check(64'(ds), 64'(byp(misc[1], misc[7] ? sw : pw)));
		check(64'(pth), 64'({path[4], ~path[4] & ~path[5], ~path[4] & path[5], path[2],
			~path[2] & path[3], ~pd & path[0], ~sd & path[1]}));
		check(64'(tune), 64'({fail & misc[6], fail & ~misc[6]}));
		rd_reg(8'h1b, path);
		rd_reg(8'h1c, misc & 8'hdf);
	endtask
	task stop_test;
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		stop_test();
	end
	initial begin
		repeat (10) @(posedge clk);
		#1 rst_n = 1;
		rd_reg(8'h1b, 8'h00);
		rd_reg(8'h1c, 8'h00);
		// Unmapped offset: write must not land, read returns zero
		wr_reg(8'h1d, 8'hff);
		rd_reg(8'h1d, 8'h00);
		for (int i = 0; i < 40; i++) begin
			step();
			path = i < 2 ? {8{i == 0}} : seed[7:0];
			misc = (i < 2 ? {8{i == 0}} : seed[15:8]) & 8'hdf;
			{pd, sd, fail, pin} = i < 2 ? {4{i == 0}} : seed[19:16];
			tw = seed[31:16];
			step();
			fw = seed[15:0];
			pw = seed[31:16];
			step();
			sw = seed[15:0];
			wr_reg(8'h1b, path);
			wr_reg(8'h1c, misc);
			check_all();
		end
		pin = 0;
		foreach (tbl[k]) begin
			wr_reg(8'h1c, tbl[k][11:4]);
			{sl, pl, pin} = tbl[k][3:1];
			repeat (3) @(posedge clk);
			#1 check(64'(act), 64'(tbl[k][0]));
		end
		stop_test();
	end
endmodule
`default_nettype wire
